// ---- rtl/torque_off_consts.vh ----
`ifndef TORQUE_OFF_CONSTS_VH
`define TORQUE_OFF_CONSTS_VH
`define CLK_PERIOD_NS 5
`define SKEW_WINDOW_MS 1000
`define SKEW_WINDOW_CYC 200000000
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_IRQ_STAT 12'h008
`define ADDR_IRQ_MASK 12'h00C
`define ADDR_CHAN 12'h010
`define CTRL_FAULT_RESET 0
`define CTRL_RUN_REQ 1
`define IRQ_VALID_SHUTOFF 0
`define IRQ_PERM_FAULT 1
`define IRQ_CHAN_CHANGE 2
`define IRQ_BITS 3
`define IRQ_RESET 3'h0
`define ST_RUN 3'h0
`define ST_SKEW 3'h1
`define ST_SHUT_OK 3'h2
`define ST_PERM 3'h3
`define ST_SHUT_ARMED 3'h4
`endif

// ---- rtl/skew_timer.v ----
`include "torque_off_consts.vh"
module skew_timer #(
  parameter WIDTH = 28,
  parameter [27:0] LIMIT = `SKEW_WINDOW_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // control
  input wire run,
  output wire expired
);
  reg [WIDTH-1:0] count_reg;
  reg [WIDTH-1:0] count_next;

  // counter restarts whenever run is low, so each skew event starts fresh
  always @* begin
    count_next = count_reg;
    if (!run)
      count_next = {WIDTH{1'b0}};
    else if (count_reg < LIMIT[WIDTH-1:0])
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always @(posedge clk_sys) begin
    if (!nrst)
      count_reg <= {WIDTH{1'b0}};
    else
      count_reg <= count_next;
  end

  assign expired = run && (count_reg >= LIMIT[WIDTH-1:0]);
endmodule // skew_timer

// ---- rtl/irq_block.v ----
`include "torque_off_consts.vh"
module irq_block #(
  parameter N = `IRQ_BITS
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // events and software access
  input wire [N-1:0] event_set,
  input wire clear_we,
  input wire mask_we,
  input wire [N-1:0] wdata,
  // state
  output reg [N-1:0] status_reg,
  output reg [N-1:0] mask_reg,
  output wire irq
);
  always @(posedge clk_sys) begin
    if (!nrst) begin
      status_reg <= `IRQ_RESET;
      mask_reg <= `IRQ_RESET;
    end else begin
      // set beats a simultaneous write-one clear
      status_reg <= (status_reg & ~(clear_we ? wdata : {N{1'b0}}))
                    | event_set;
      if (mask_we)
        mask_reg <= wdata;
    end
  end

  assign irq = |(status_reg & mask_reg);
endmodule // irq_block

// ---- rtl/torque_off_monitor.v ----
// Contract
// - two redundant shutoff channels, kept separate
// - both off within one second is valid
// - valid shutoff disables stage, raises fault
// - restart only after fault reset command
// - single channel or skew: power-cycle fault
// - torque drops at once, no brake delay
// - controlled stop is not supervised here
// - no supply interruption, no standstill check
`include "torque_off_consts.vh"
module torque_off_monitor #(
  parameter TIMER_WIDTH = 28,
  parameter [27:0] SKEW_CYCLES = `SKEW_WINDOW_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // shutoff channels, high means enabled
  input wire safe_torque_shutoff_a,
  input wire safe_torque_shutoff_b,
  // power stage
  output reg stage_enable,
  output reg brake_release,
  output reg fault,
  output reg perm_fault,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq
);
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg a_prev_reg;
  reg b_prev_reg;
  reg run_req_reg;
  reg first_a_reg;
  reg [`IRQ_BITS-1:0] ev;
  wire [`IRQ_BITS-1:0] irq_status;
  wire [`IRQ_BITS-1:0] irq_mask;
  wire wr;
  wire rd;
  wire fault_reset_cmd;
  wire both_on;
  wire both_off;
  wire one_off;
  wire skew_run;
  wire skew_expired;
  reg [31:0] rdata_next;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `ADDR_CTRL) || (a == `ADDR_STATUS) ||
               (a == `ADDR_IRQ_STAT) || (a == `ADDR_IRQ_MASK) ||
               (a == `ADDR_CHAN);
    end
  endfunction

  // zero wait state slave
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign wr = psel && penable && pwrite && mapped(paddr);
  assign rd = psel && !penable && !pwrite;
  assign fault_reset_cmd = wr && (paddr == `ADDR_CTRL) &&
                           pwdata[`CTRL_FAULT_RESET];

  // each channel is watched on its own input
  assign both_on = safe_torque_shutoff_a && safe_torque_shutoff_b;
  assign both_off = !safe_torque_shutoff_a && !safe_torque_shutoff_b;
  assign one_off = safe_torque_shutoff_a ^ safe_torque_shutoff_b;

  assign skew_run = (state_reg == `ST_SKEW);

  skew_timer #(
    .WIDTH(TIMER_WIDTH),
    .LIMIT(SKEW_CYCLES)
  ) u_skew (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(skew_run),
    .expired(skew_expired)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_RUN: begin
        if (both_off)
          state_next = `ST_SHUT_OK;
        else if (one_off)
          state_next = `ST_SKEW;
      end
      `ST_SKEW: begin
        // window opened by first channel going off
        if (skew_expired)
          state_next = `ST_PERM;
        else if (both_off)
          state_next = `ST_SHUT_OK;
        else if (both_on)
          state_next = `ST_PERM;
        else if (first_a_reg != !safe_torque_shutoff_a)
          state_next = `ST_PERM;
      end
      `ST_SHUT_OK: begin
        // stays latched until fault reset with channels restored
        if (one_off && !both_off)
          state_next = `ST_SHUT_OK;
        if (fault_reset_cmd && both_on)
          state_next = `ST_SHUT_ARMED;
      end
      `ST_SHUT_ARMED: begin
        // restart needs a deliberate run request after the reset
        if (!both_on)
          state_next = one_off ? `ST_SKEW : `ST_SHUT_OK;
        else if (run_req_reg)
          state_next = `ST_RUN;
      end
      `ST_PERM: state_next = `ST_PERM; // only nrst clears it
      default: state_next = `ST_PERM;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= `ST_SHUT_ARMED;
      // idle level is enabled, so no false change event after reset
      a_prev_reg <= 1'b1;
      b_prev_reg <= 1'b1;
      first_a_reg <= 1'b0;
      run_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      a_prev_reg <= safe_torque_shutoff_a;
      b_prev_reg <= safe_torque_shutoff_b;
      if (state_next == `ST_SKEW && state_reg != `ST_SKEW)
        first_a_reg <= !safe_torque_shutoff_a;
      if (wr && paddr == `ADDR_CTRL)
        run_req_reg <= pwdata[`CTRL_RUN_REQ];
      else if (state_reg != `ST_SHUT_ARMED && state_reg != `ST_RUN)
        run_req_reg <= 1'b0;
    end
  end

  // stage is registered and drops one clock after the channels, brake delay is bypassed
  // no standstill or decel check is done
  always @(posedge clk_sys) begin
    if (!nrst) begin
      stage_enable <= 1'b0;
      brake_release <= 1'b0;
      fault <= 1'b0;
      perm_fault <= 1'b0;
    end else begin
      stage_enable <= (state_next == `ST_RUN) && both_on;
      brake_release <= (state_next == `ST_RUN) && both_on;
      fault <= (state_next == `ST_SHUT_OK) ||
               (state_next == `ST_SKEW) ||
               (state_next == `ST_PERM);
      perm_fault <= (state_next == `ST_PERM);
    end
  end

  always @* begin
    ev = {`IRQ_BITS{1'b0}};
    ev[`IRQ_VALID_SHUTOFF] = (state_next == `ST_SHUT_OK) &&
                             (state_reg != `ST_SHUT_OK);
    ev[`IRQ_PERM_FAULT] = (state_next == `ST_PERM) &&
                          (state_reg != `ST_PERM);
    ev[`IRQ_CHAN_CHANGE] = (a_prev_reg != safe_torque_shutoff_a) ||
                           (b_prev_reg != safe_torque_shutoff_b);
  end

  irq_block #(
    .N(`IRQ_BITS)
  ) u_irq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .event_set(ev),
    .clear_we(wr && paddr == `ADDR_IRQ_STAT),
    .mask_we(wr && paddr == `ADDR_IRQ_MASK),
    .wdata(pwdata[`IRQ_BITS-1:0]),
    .status_reg(irq_status),
    .mask_reg(irq_mask),
    .irq(irq)
  );

  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `ADDR_CTRL: rdata_next = {30'h0, run_req_reg, 1'b0};
      `ADDR_STATUS: rdata_next = {25'h0, state_reg, perm_fault, fault,
                                  brake_release, stage_enable};
      `ADDR_IRQ_STAT: rdata_next = {29'h0, irq_status};
      `ADDR_IRQ_MASK: rdata_next = {29'h0, irq_mask};
      `ADDR_CHAN: rdata_next = {30'h0, safe_torque_shutoff_b,
                                safe_torque_shutoff_a};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read data captured in setup so it is stable in the access phase
  always @(posedge clk_sys) begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (rd)
      prdata <= rdata_next;
  end
endmodule // torque_off_monitor

// ---- verif/estop_model.sv ----
module estop_model (
  // clock
  input wire logic clk_sys,
  // contact commands from the bench
  input wire logic open_a,
  input wire logic open_b,
  // channel outputs, high means enabled
  output logic chan_a = 1'b1,
  output logic chan_b = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  // two separate contacts, never tied together, so skew is real
  always @(posedge clk_sys) begin
    chan_a <= !open_a;
    chan_b <= !open_b;
  end
endmodule // estop_model

// ---- verif/torque_off_properties.sv ----
`include "torque_off_consts.vh"
module torque_off_properties #(
  parameter TIMER_WIDTH = 28,
  parameter [27:0] SKEW_CYCLES = 28'd20
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // channels and stage
  input wire safe_torque_shutoff_a,
  input wire safe_torque_shutoff_b,
  input wire stage_enable,
  input wire brake_release,
  input wire fault,
  input wire perm_fault,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq
);
  wire a = safe_torque_shutoff_a;
  wire b = safe_torque_shutoff_b;
  wire ctl_wr = psel && penable && pwrite && paddr == `ADDR_CTRL;
  wire hit = paddr == `ADDR_CTRL || paddr == `ADDR_STATUS ||
    paddr == `ADDR_IRQ_STAT || paddr == `ADDR_IRQ_MASK ||
    paddr == `ADDR_CHAN;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_READY: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  AST_SLVERR: assert property (psel && penable |->
    pslverr == !hit) else $error("bad pslverr");
  AST_BOTH_OFF: assert property (stage_enable && !a && !b |=>
    !stage_enable && fault) else $error("stage kept on");
  AST_ONE_OFF: assert property (stage_enable && (a ^ b) |=>
    !stage_enable && fault) else $error("single channel ignored");
  AST_PERM_HOLD: assert property (perm_fault |=>
    perm_fault && !stage_enable) else $error("perm fault lost");
  AST_STAGE_CHAN: assert property (stage_enable |->
    $past(a && b)) else $error("stage on with channel off");
  AST_RESTART: assert property ($rose(stage_enable) |->
    $past(ctl_wr) || $past(ctl_wr, 2)) else $error("restart alone");
  AST_BRAKE: assert property (stage_enable && !(a && b) |=>
    !stage_enable && !brake_release) else $error("brake delay applied");
  COV_VALID: cover property (stage_enable && !a && !b);
  COV_PERM: cover property ($rose(perm_fault));
  COV_RESTART: cover property ($rose(stage_enable) && fault == 1'b0);
endmodule // torque_off_properties
bind torque_off_monitor torque_off_properties #(
  .TIMER_WIDTH(TIMER_WIDTH), .SKEW_CYCLES(SKEW_CYCLES)) props_u (.*);

// ---- verif/dual_channel_torque_off_monitor_bench.sv ----
`include "torque_off_consts.vh"
module dual_channel_torque_off_monitor_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SK = 20;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic open_a = 0, open_b = 0, ch_a, ch_b, stage, brake, flt, perm;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq, err;
  int failures = 0, checks_done = 0;
  estop_model model_u (.clk_sys(clk_sys), .open_a(open_a),
    .open_b(open_b), .chan_a(ch_a), .chan_b(ch_b));
  torque_off_monitor #(.SKEW_CYCLES(28'd20)) dut_u (.clk_sys(clk_sys),
    .nrst(nrst), .safe_torque_shutoff_a(ch_a),
    .safe_torque_shutoff_b(ch_b), .stage_enable(stage),
    .brake_release(brake), .fault(flt), .perm_fault(perm),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  initial begin
    forever #2.5 clk_sys = !clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // one idle edge so a following call never reassigns psel at once
    @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #30000;
    failures++;
    report_and_stop;
  end
  initial begin
    cyc(8);
    nrst <= 1;
    cyc(1);
    apb(0, `ADDR_STATUS, 0);
    chk(rd, 32'h0000_0040);
    apb(1, `ADDR_IRQ_MASK, 32'h7);
    apb(1, `ADDR_CTRL, 32'h2);
    cyc(3);
    chk({31'h0, stage}, 32'h1);
    $display("test 1 done");
    open_a <= 1;
    cyc(SK - 2);
    open_b <= 1;
    cyc(3);
    chk({28'h0, stage, brake, flt, perm}, 32'h2);
    apb(0, `ADDR_IRQ_STAT, 0);
    chk(rd & 32'h3, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1, `ADDR_IRQ_STAT, 32'h7);
    open_a <= 0;
    open_b <= 0;
    apb(1, `ADDR_CTRL, 32'h2);
    cyc(3);
    chk({31'h0, stage}, 32'h0);
    apb(1, `ADDR_CTRL, 32'h1);
    apb(1, `ADDR_CTRL, 32'h2);
    cyc(3);
    chk({30'h0, stage, flt}, 32'h2);
    $display("test 2 done");
    apb(1, `ADDR_IRQ_STAT, 32'h7);
    apb(1, `ADDR_IRQ_MASK, 32'h0);
    open_b <= 1;
    cyc(SK + 5);
    open_b <= 0;
    cyc(3);
    chk({29'h0, stage, perm, irq}, 32'h2);
    apb(0, `ADDR_IRQ_STAT, 0);
    chk(rd & 32'h2, 32'h2);
    apb(1, `ADDR_CTRL, 32'h1);
    apb(1, `ADDR_CTRL, 32'h2);
    cyc(3);
    chk({30'h0, stage, perm}, 32'h1);
    apb(0, 12'h020, 0);
    chk({31'h0, err}, 32'h1); // unmapped read refused
    chk(rd, 32'h0); // unmapped read gives zero
    $display("test 3 done");
    nrst <= 0;
    cyc(2);
    nrst <= 1;
    cyc(4);
    chk({30'h0, stage, perm}, 32'h0);
    $display("test 4 done");
    report_and_stop;
  end
endmodule // dual_channel_torque_off_monitor_bench
